// ---- design/dmbd_regs.svh ----
// Address map constants for the data memory bank decoder.
// Assumes inclusion by the package and the design modules only.
`ifndef DMBD_REGS_SVH
`define DMBD_REGS_SVH

// ----------------------------------------------------------------
// Banks and address ranges
// ----------------------------------------------------------------
`define DMBD_BANK_RAM      4'h0
`define DMBD_BANK_PER      4'hf
`define DMBD_RAM_TOP       8'h3f
`define DMBD_RAM_BYTE_TOP  8'h3e
`define DMBD_PER_BASE      8'h80
`define DMBD_FBIT_IRQ_PAGE 4'hb
`define DMBD_FBIT_IO_PAGE  4'hf
`define DMBD_STACK_TOP3    3'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMBD_PTR_RESET     8'h00
`define DMBD_STACK_RESET   5'h00

`endif

// ---- design/dmbd_pkg.sv ----
// Types shared by the data memory bank decoder and its RAM.
// Assumes the constant header is on the include path.
package dmbd_pkg;

  // ----------------------------------------------------------------
  // Addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DMBD_MODE_BIT1  = 3'b000,  // 1-bit direct
    DMBD_MODE_NIB4  = 3'b001,  // 4-bit direct
    DMBD_MODE_BYTE8 = 3'b010,  // 8-bit direct, even operand
    DMBD_MODE_PIND  = 3'b011,  // Pointer pair indirect
    DMBD_MODE_FBIT  = 3'b100,  // Fixed-page bit
    DMBD_MODE_STACK = 3'b101,  // Stack pointer indirect
    DMBD_MODE_PTR   = 3'b110   // Pointer register operation
  } dmbd_mode_e;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DMBD_OP_READ      = 4'h0,  // Move memory to accumulator
    DMBD_OP_WRITE     = 4'h1,  // Move accumulator to memory
    DMBD_OP_EXCHANGE  = 4'h2,  // Swap accumulator and memory
    DMBD_OP_INC_SKIP  = 4'h3,  // Increment, skip on zero
    DMBD_OP_BIT_SET   = 4'h4,
    DMBD_OP_BIT_CLEAR = 4'h5,
    DMBD_OP_SKIP_TRUE = 4'h6,
    DMBD_OP_SKIP_FALSE= 4'h7,
    DMBD_OP_BIT_AND   = 4'h8,  // Carry and bit
    DMBD_OP_BIT_OR    = 4'h9,
    DMBD_OP_BIT_XOR   = 4'ha,
    DMBD_OP_TEST_CLR  = 4'hb,  // Test, clear, skip if set
    DMBD_OP_PTR_LOAD  = 4'hc,
    DMBD_OP_PTR_INC   = 4'hd,  // Pointer increment, skip on zero
    DMBD_OP_PTR_DEC   = 4'he,  // Pointer decrement, skip on ff
    DMBD_OP_STK_LOAD  = 4'hf
  } dmbd_op_e;

  // Sequencer states
  typedef enum logic [1:0] {
    DMBD_ST_IDLE   = 2'b00,
    DMBD_ST_READ   = 2'b01,
    DMBD_ST_MODIFY = 2'b10,
    DMBD_ST_WRITE  = 2'b11
  } dmbd_st_e;

  // Request from the execution logic
  typedef struct packed {
    dmbd_mode_e  mode;
    dmbd_op_e    op;
    logic [7:0]  operand;   // Direct address; pointer modes ignore it
    logic [1:0]  bit_sel;   // Bit within the nibble
    logic [7:0]  acc;       // Accumulator pair, low nibble even
    logic        carry;
  } dmbd_req_s;

  // Answer to the execution logic
  typedef struct packed {
    logic        hit;       // A real location was reached, or a pointer operation was done
    logic        skip;
    logic        carry;
    logic [7:0]  data;
  } dmbd_resp_s;

  // Peripheral bank access, registered part
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        byte_wide;
  } dmbd_per_s;

endpackage

// ---- design/dmbd_ram.sv ----
// 64 x 4 static RAM held as 32 nibble pairs with lane writes.
// Assumes one clock; read data appear one edge after the address.
`timescale 1ns/1ps
module dmbd_ram
  import dmbd_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Access
  input  wire logic [4:0] pair_addr,  // Nibble address bits 5..1
  input  wire logic       we_lo,      // Write even nibble
  input  wire logic       we_hi,      // Write odd nibble
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata       // Registered pair
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:31];             // Contents undefined at power-up
  logic [7:0] rdata_r;

  // Lane writes and registered read
  always_ff @(posedge sys_clk)
  begin
    if (we_lo)
    begin
      mem[pair_addr][3:0] <= wdata[3:0];
    end
    if (we_hi)
    begin
      mem[pair_addr][7:4] <= wdata[7:4];
    end
    rdata_r <= mem[pair_addr];
  end

  assign rdata = rdata_r;

endmodule

// ---- design/dmbd_decoder.sv ----
// Data memory address generation and bank decoder.
// Assumes the execution logic and the peripheral bank share sys_clk.
`timescale 1ns/1ps
`include "dmbd_regs.svh"

module dmbd_decoder
  import dmbd_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Request from execution logic
  input  wire logic       req_valid,
  input  dmbd_req_s       req,
  output logic            req_ready,
  // Answer to execution logic
  output logic            resp_valid,
  output dmbd_resp_s      resp,
  // Pointer registers
  output logic      [7:0] indirect_pointer_pair,
  output logic      [7:0] stack_pointer,
  // Peripheral bank
  output dmbd_per_s       per,
  output logic            per_rd,
  output logic            per_wr,
  input  wire logic [7:0] per_rdata,
  input  wire logic       per_bit_ok,   // Addressed bit is bit-capable
  input  wire logic       per_byte_ok   // Addressed pair is byte-capable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dmbd_st_e    st;
    dmbd_mode_e  mode;
    dmbd_op_e    op;
    logic [11:0] addr;        // Bank nibble and low address
    logic        to_ram;
    logic        to_per;
    logic [1:0]  bit_sel;
    logic [7:0]  acc;
    logic        carry;
    logic        cap_ok;      // Peripheral accepts this width
    logic [7:0]  wdata;       // Data for the write phase
    logic        do_write;
    dmbd_resp_s  resp;
    logic [7:0]  ptr_pair;
    logic [4:0]  stk_low;     // Stack pointer bits 4..0
  } dmbd_state_s;

  dmbd_state_s s_r;           // Registered state
  dmbd_state_s s_nxt;         // Next state

  logic [7:0]  ram_rdata;     // RAM pair read data
  logic        ram_we_lo;
  logic        ram_we_hi;

  // ----------------------------------------------------------------
  // Operation legality per mode
  // ----------------------------------------------------------------
  function automatic logic op_legal(dmbd_mode_e m, dmbd_op_e o);
    logic ok;
    ok = 1'b0;
    unique case (m)
      DMBD_MODE_BIT1:
        ok = (o == DMBD_OP_BIT_SET) || (o == DMBD_OP_BIT_CLEAR) ||
             (o == DMBD_OP_SKIP_TRUE) || (o == DMBD_OP_SKIP_FALSE);
      DMBD_MODE_NIB4, DMBD_MODE_PIND:
        ok = (o == DMBD_OP_READ) || (o == DMBD_OP_WRITE) ||
             (o == DMBD_OP_EXCHANGE) || (o == DMBD_OP_INC_SKIP);
      DMBD_MODE_BYTE8:
        ok = (o == DMBD_OP_READ) || (o == DMBD_OP_WRITE) ||
             (o == DMBD_OP_EXCHANGE);
      DMBD_MODE_FBIT:
        ok = (o >= DMBD_OP_BIT_SET) && (o <= DMBD_OP_TEST_CLR);
      DMBD_MODE_STACK:
        ok = (o == DMBD_OP_READ) || (o == DMBD_OP_WRITE);
      DMBD_MODE_PTR:
        ok = (o >= DMBD_OP_PTR_LOAD);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] d8;           // Data read from the selected bank
    logic [3:0] nib;          // Addressed nibble
    logic [3:0] wn;           // Nibble to write back
    logic       bv;           // Addressed bit
    logic [7:0] pv;           // New pointer value
    d8    = s_r.to_ram ? ram_rdata : per_rdata;
    nib   = (s_r.to_ram && s_r.addr[0]) ? d8[7:4] : d8[3:0];
    bv    = nib[s_r.bit_sel];
    wn    = nib;
    pv    = s_r.ptr_pair;
    s_nxt = s_r;
    unique case (s_r.st)
      // Take a request and decode its bank
      DMBD_ST_IDLE:
      begin
        s_nxt.mode     = req.mode;
        s_nxt.op       = req.op;
        s_nxt.bit_sel  = req.bit_sel;
        s_nxt.acc      = req.acc;
        s_nxt.carry    = req.carry;
        s_nxt.to_ram   = 1'b0;
        s_nxt.to_per   = 1'b0;
        s_nxt.do_write = 1'b0;
        s_nxt.cap_ok   = 1'b1;
        s_nxt.resp     = '0;
        s_nxt.addr     = {`DMBD_BANK_PER, req.operand};
        if (req_valid)
        begin
          unique case (req.mode)
            // Bank by operand range
            DMBD_MODE_BIT1, DMBD_MODE_NIB4:
            begin
              if (req.operand <= `DMBD_RAM_TOP)
              begin
                s_nxt.to_ram = 1'b1;
              end
              else if (req.operand >= `DMBD_PER_BASE)
              begin
                s_nxt.to_per = 1'b1;
              end
            end
            // Even operands only
            DMBD_MODE_BYTE8:
            begin
              if (req.operand[0])
              begin
                s_nxt.to_ram = 1'b0;
              end
              else if (req.operand <= `DMBD_RAM_BYTE_TOP)
              begin
                s_nxt.to_ram = 1'b1;
              end
              else if (req.operand >= `DMBD_PER_BASE)
              begin
                s_nxt.to_per = 1'b1;
              end
            end
            // Pointer pair reaches bank 0 RAM only
            DMBD_MODE_PIND:
            begin
              s_nxt.to_ram = (s_r.ptr_pair <= `DMBD_RAM_TOP);
            end
            // Two fixed pages of bank 15
            DMBD_MODE_FBIT:
            begin
              s_nxt.to_per = (req.operand[7:4] == `DMBD_FBIT_IRQ_PAGE)
                          || (req.operand[7:4] == `DMBD_FBIT_IO_PAGE);
            end
            // Stack window in bank 0
            DMBD_MODE_STACK:
            begin
              s_nxt.to_ram = 1'b1;
            end
            // Pointer operations need no memory
            default:
            begin
              s_nxt.to_ram = 1'b0;
            end
          endcase
          // Bank 0 address forms
          if (s_nxt.to_ram)
          begin
            s_nxt.addr[11:8] = `DMBD_BANK_RAM;
          end
          if (req.mode == DMBD_MODE_PIND)
          begin
            s_nxt.addr[7:0] = s_r.ptr_pair;
          end
          if (req.mode == DMBD_MODE_STACK)
          begin
            s_nxt.addr[7:0] = {`DMBD_STACK_TOP3, s_r.stk_low};
          end
          // Illegal operation for the mode reaches nothing
          if (!op_legal(req.mode, req.op))
          begin
            s_nxt.to_ram = 1'b0;
            s_nxt.to_per = 1'b0;
          end
          if (req.mode == DMBD_MODE_PTR && op_legal(req.mode, req.op))
          begin
            // Pointer register operations
            s_nxt.resp.hit = 1'b1;
            unique case (req.op)
              DMBD_OP_PTR_LOAD:
              begin
                pv = req.acc;
              end
              DMBD_OP_PTR_INC:
              begin
                pv = s_r.ptr_pair + 8'h01;
                s_nxt.resp.skip = (pv == 8'h00);
              end
              DMBD_OP_PTR_DEC:
              begin
                pv = s_r.ptr_pair - 8'h01;
                s_nxt.resp.skip = (pv == 8'hff);
              end
              default:
              begin
                s_nxt.stk_low = req.acc[4:0];
              end
            endcase
            s_nxt.ptr_pair  = pv;
            s_nxt.resp.data = (req.op == DMBD_OP_STK_LOAD) ?
                              {`DMBD_STACK_TOP3, req.acc[4:0]} : pv;
            s_nxt.st = DMBD_ST_WRITE;
          end
          else if (s_nxt.to_ram || s_nxt.to_per)
          begin
            s_nxt.st = DMBD_ST_READ;
          end
          else
          begin
            // Nothing decoded: answer with no access
            s_nxt.st = DMBD_ST_WRITE;
          end
        end
      end
      // Read issued; sample peripheral capability
      DMBD_ST_READ:
      begin
        if (s_r.to_per && s_r.mode == DMBD_MODE_BYTE8)
        begin
          s_nxt.cap_ok = per_byte_ok;
        end
        else if (s_r.to_per && s_r.mode == DMBD_MODE_BIT1)
        begin
          s_nxt.cap_ok = per_bit_ok;
        end
        s_nxt.st = DMBD_ST_MODIFY;
      end
      // Data back: compute answer and write data
      DMBD_ST_MODIFY:
      begin
        s_nxt.resp.hit  = s_r.cap_ok;
        s_nxt.resp.data = (s_r.mode == DMBD_MODE_BYTE8) ?
                          d8 : {4'h0, nib};
        s_nxt.resp.carry = s_r.carry;
        unique case (s_r.op)
          DMBD_OP_WRITE, DMBD_OP_EXCHANGE:
          begin
            s_nxt.do_write = 1'b1;
            wn = s_r.acc[3:0];
          end
          DMBD_OP_INC_SKIP:
          begin
            wn = nib + 4'h1;
            s_nxt.do_write  = 1'b1;
            s_nxt.resp.skip = (wn == 4'h0);
            s_nxt.resp.data = {4'h0, wn};
          end
          DMBD_OP_BIT_SET:
          begin
            wn[s_r.bit_sel] = 1'b1;
            s_nxt.do_write  = 1'b1;
          end
          DMBD_OP_BIT_CLEAR:
          begin
            wn[s_r.bit_sel] = 1'b0;
            s_nxt.do_write  = 1'b1;
          end
          DMBD_OP_SKIP_TRUE:
          begin
            s_nxt.resp.skip = bv;
          end
          DMBD_OP_SKIP_FALSE:
          begin
            s_nxt.resp.skip = !bv;
          end
          DMBD_OP_BIT_AND:
          begin
            s_nxt.resp.carry = s_r.carry & bv;
          end
          DMBD_OP_BIT_OR:
          begin
            s_nxt.resp.carry = s_r.carry | bv;
          end
          DMBD_OP_BIT_XOR:
          begin
            s_nxt.resp.carry = s_r.carry ^ bv;
          end
          DMBD_OP_TEST_CLR:
          begin
            s_nxt.resp.skip = bv;
            wn[s_r.bit_sel] = 1'b0;
            s_nxt.do_write  = bv;
          end
          default:
          begin
            s_nxt.do_write = 1'b0;
          end
        endcase
        // Byte wide moves carry the whole pair
        s_nxt.wdata = (s_r.mode == DMBD_MODE_BYTE8) ?
                      s_r.acc : {wn, wn};
        // Refused peripheral width: no effect at all
        if (!s_r.cap_ok)
        begin
          s_nxt.do_write  = 1'b0;
          s_nxt.resp.skip = 1'b0;
          s_nxt.resp.data = 8'h00;
        end
        s_nxt.st = DMBD_ST_WRITE;
      end
      // Write phase and answer
      DMBD_ST_WRITE:
      begin
        s_nxt.st = DMBD_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_r          <= '0;
      s_r.st       <= DMBD_ST_IDLE;
      s_r.ptr_pair <= `DMBD_PTR_RESET;
      s_r.stk_low  <= `DMBD_STACK_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Static RAM
  // ----------------------------------------------------------------
  // Lane writes only on a decoded RAM hit
  assign ram_we_lo = (s_r.st == DMBD_ST_WRITE) && s_r.to_ram &&
                     s_r.do_write &&
                     (s_r.mode == DMBD_MODE_BYTE8 || !s_r.addr[0]);
  assign ram_we_hi = (s_r.st == DMBD_ST_WRITE) && s_r.to_ram &&
                     s_r.do_write &&
                     (s_r.mode == DMBD_MODE_BYTE8 || s_r.addr[0]);

  dmbd_ram u_ram
  (
    .sys_clk   (sys_clk),
    .pair_addr (s_r.addr[5:1]),
    .we_lo     (ram_we_lo),
    .we_hi     (ram_we_hi),
    .wdata     (s_r.wdata),
    .rdata     (ram_rdata)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready  = (s_r.st == DMBD_ST_IDLE);
  assign resp_valid = (s_r.st == DMBD_ST_WRITE);
  assign resp       = s_r.resp;

  // Pointer registers; stack upper bits fixed
  assign indirect_pointer_pair = s_r.ptr_pair;
  assign stack_pointer         = {`DMBD_STACK_TOP3, s_r.stk_low};

  // Peripheral bank port
  assign per.addr      = s_r.addr;
  assign per.wdata     = s_r.wdata;
  assign per.byte_wide = (s_r.mode == DMBD_MODE_BYTE8);

  // Read strobe only where the width is accepted
  assign per_rd = (s_r.st == DMBD_ST_READ) && s_r.to_per &&
                  (s_r.op != DMBD_OP_WRITE) &&
                  !(s_r.mode == DMBD_MODE_BYTE8 && !per_byte_ok) &&
                  !(s_r.mode == DMBD_MODE_BIT1 && !per_bit_ok);
  assign per_wr = (s_r.st == DMBD_ST_WRITE) && s_r.to_per &&
                  s_r.do_write && s_r.cap_ok;

endmodule

// ---- test/dmbd_per_model.sv ----
// Peripheral bank model on the far side of the decoder.
// Assumes it shares sys_clk with the decoder.
`timescale 1ns/1ps
module dmbd_per_model
  import dmbd_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Bank access
  input  dmbd_per_s       per,
  input  wire logic       per_rd,
  input  wire logic       per_wr,
  output logic      [7:0] per_rdata,
  output logic            per_bit_ok,
  output logic            per_byte_ok
);
  logic [3:0] mem [128];  // Nibbles F80..FFF
  logic [7:0] dq;         // Captured pair
  logic       rd_q;       // Read window open
  logic [6:0] a;          // Offset in bank
  assign a = per.addr[6:0];
  // Capability pattern of this model
  assign per_bit_ok  = ~per.addr[1];
  assign per_byte_ok = ~per.addr[2];
  // Outside the window the bus shows the inverse
  assign per_rdata = rd_q ? dq : ~dq;
  initial
  begin
    rd_q = 1'b0;
    dq = 8'h00;
    for (int i = 0; i < 128; i++)
      mem[i] = 4'(i ^ (i >> 4));
  end
  // Read capture and writes
  always @(posedge sys_clk)
  begin
    rd_q <= per_rd;
    if (per_rd)
      dq <= {mem[a | 7'h01], mem[a]};
    if (per_wr)
      mem[a] <= per.wdata[3:0];
    if (per_wr && per.byte_wide)
      mem[a | 7'h01] <= per.wdata[7:4];
  end
endmodule

// ---- test/dmbd_decoder_assertions.sv ----
// Port checker for the data memory bank decoder.
// Assumes a bind onto dmbd_decoder; one clock, synchronous reset.
`timescale 1ns/1ps
module dmbd_decoder_assertions
  import dmbd_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Request and answer
  input wire logic       req_valid,
  input dmbd_req_s       req,
  input wire logic       req_ready,
  input wire logic       resp_valid,
  input dmbd_resp_s      resp,
  // Pointers and peripheral bank
  input wire logic [7:0] indirect_pointer_pair,
  input wire logic [7:0] stack_pointer,
  input dmbd_per_s       per,
  input wire logic       per_rd,
  input wire logic       per_wr,
  input wire logic       per_bit_ok,
  input wire logic       per_byte_ok
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic tk;  // Request taken
  assign tk = req_valid && req_ready;
  // ----------------------------------------
  // Steps
  // ----------------------------------------
  sequence s_bit_per;
    tk && req.mode == DMBD_MODE_BIT1 && req.operand[7] &&
    req.op >= DMBD_OP_BIT_SET && req.op <= DMBD_OP_SKIP_FALSE;
  endsequence
  sequence s_refused;
    !per_rd ##2 (!per_wr && resp_valid && !resp.hit);
  endsequence
  sequence s_quiet;
    (!per_rd && !per_wr) [*3];
  endsequence
  // Undecoded request answered at once, then idle again
  sequence s_missed;
    (resp_valid && !per_rd && !per_wr) ##1 req_ready;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  stack_upper_a: assert property (
    stack_pointer[7:5] == 3'b001) else $error("stack upper bits");
  per_bank_a: assert property (
    per_rd || per_wr |-> per.addr[11:7] == 5'h1f) else $error("bank");
  byte_even_a: assert property (
    (per_rd || per_wr) && per.byte_wide |-> !per.addr[0])
    else $error("odd byte address");
  byte_cap_a: assert property (
    per_rd && per.byte_wide |-> per_byte_ok) else $error("byte cap");
  bit_refuse_a: assert property (
    s_bit_per ##1 !per_bit_ok |-> s_refused) else $error("bit cap");
  bit_rmw_a: assert property (
    (s_bit_per ##0 req.op == DMBD_OP_BIT_SET) ##1 per_rd |-> ##2 per_wr)
    else $error("bit set write");
  pind_bank_a: assert property (
    tk && req.mode == DMBD_MODE_PIND |=> s_quiet or s_missed)
    else $error("pind");
  stack_bank_a: assert property (
    tk && req.mode == DMBD_MODE_STACK |=> s_quiet or s_missed)
    else $error("stk");
  ram_time_a: assert property (
    tk && req.mode == DMBD_MODE_NIB4 && req.op == DMBD_OP_READ &&
    req.operand <= 8'h3f |-> ##3 (resp_valid && resp.hit))
    else $error("ram read answer");
  gap_miss_a: assert property (
    tk && req.mode == DMBD_MODE_NIB4 && req.operand[7:6] == 2'b01
    |-> ##1 (resp_valid && !resp.hit)) else $error("gap hit");
  fbit_hit_a: assert property (
    tk && req.mode == DMBD_MODE_FBIT && req.operand[7:4] == 4'hf &&
    req.op >= DMBD_OP_BIT_SET && req.op <= DMBD_OP_TEST_CLR
    |-> ##3 (resp_valid && resp.hit)) else $error("fixed page");
  ptr_inc_a: assert property (
    tk && req.mode == DMBD_MODE_PTR && req.op == DMBD_OP_PTR_INC |->
    ##1 (resp_valid &&
    resp.data == 8'($past(indirect_pointer_pair) + 8'h01)))
    else $error("pointer increment");
endmodule

bind dmbd_decoder dmbd_decoder_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
  .indirect_pointer_pair(indirect_pointer_pair),
  .stack_pointer(stack_pointer), .per(per), .per_rd(per_rd),
  .per_wr(per_wr), .per_bit_ok(per_bit_ok), .per_byte_ok(per_byte_ok));

// ---- test/testbench.sv ----
// Self-checking bench for the data memory bank decoder.
// Assumes the peripheral model and the bound checker.
`timescale 1ns/1ps
module testbench
  import dmbd_pkg::*;
;
  logic        sys_clk = 0, rst_n = 0, req_valid = 0;
  logic        req_ready, resp_valid, per_rd, per_wr, bit_ok, byte_ok;
  dmbd_req_s   req = '0;
  dmbd_resp_s  resp;
  dmbd_per_s   per;
  logic [7:0]  ipp, sp, per_rdata;
  logic [31:0] seed = 32'h427e5f2d;
  logic [31:0] r;
  int          mismatches, compares, cycles, ptr, sp5, m[4096];
  int          bnd[8] = '{'h3e, 'h3f, 'h40, 'h7f, 'h80, 'h84, 'hfe, 'hff};

  always #50 sys_clk = ~sys_clk;

  dmbd_decoder i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp(resp), .indirect_pointer_pair(ipp),
    .stack_pointer(sp), .per(per), .per_rd(per_rd), .per_wr(per_wr),
    .per_rdata(per_rdata), .per_bit_ok(bit_ok), .per_byte_ok(byte_ok));
  dmbd_per_model i_per (.sys_clk(sys_clk), .per(per), .per_rd(per_rd),
    .per_wr(per_wr), .per_rdata(per_rdata), .per_bit_ok(bit_ok),
    .per_byte_ok(byte_ok));

  // Seeded xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input int e, input string s);
    compares++;
    if (got !== 8'(e))
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, 8'(e));
    end
  endtask

  // Model store of nibbles
  task automatic wr(input int a, d, w);
    m[a] = d & 15;
    if (w)
      m[a + 1] = d >> 4 & 15;
  endtask

  // One request: model, drive, wait, compare
  task automatic run(input int md, op, opd, bs, acc, cy);
    int a, v, b, w, k, h, dv, sk, c, pm;
    a = -1;
    w = md == 2;
    pm = md == 6 && op > 11;
    sk = 0;
    c = cy;
    if ((md < 2 || w && !opd[0]) && (opd < 'h40 || opd > 'h7f))
      a = opd > 'h7f ? 'hf00 + opd : opd;
    if (md == 0 && !(op inside {[4:7]}) || md == 1 && op > 3 || w && op > 2)
      a = -1;
    if (a > 'hf00 && (md == 0 && a[1] || w && a[2]))
      a = -1;
    if (md == 3 && op < 4 && ptr < 'h40)
      a = ptr;
    if (md == 4 && op inside {[4:11]} && opd[7:4] inside {'hb, 'hf})
      a = 'hf00 + opd;
    if (md == 5 && op < 2)
      a = 'h20 + sp5;
    h = a >= 0;
    v = h ? m[a] + (w ? m[a + 1] << 4 : 0) : 0;
    b = v >> bs & 1;
    dv = v;
    if (h)
      case (op)
        1, 2: wr(a, acc, w);
        3: dv = (v + 1) & 15;
        4: wr(a, v | 1 << bs, 0);
        5, 11: wr(a, v & ~(1 << bs), 0);
        6: sk = b;
        7: sk = !b;
        8: c = cy & b;
        9: c = cy | b;
        10: c = cy ^ b;
        default: ;
      endcase
    if (h && op == 3)
      wr(a, dv, 0);
    if (h && op inside {3, 11})
      sk = op == 3 ? dv == 0 : b;
    if (pm)
      case (op)
        12: ptr = acc & 255;
        13: ptr = (ptr + 1) & 255;
        14: ptr = (ptr - 1) & 255;
        default: sp5 = acc & 31;
      endcase
    if (pm && op inside {13, 14})
      sk = ptr == (op == 13 ? 0 : 255);
    if (pm)
      dv = op == 15 ? 'h20 + sp5 : ptr;
    req <= '{dmbd_mode_e'(md), dmbd_op_e'(op), 8'(opd), 2'(bs), 8'(acc),
             1'(cy)};
    req_valid <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (req_ready !== 1'b1 && k < 8);
    req_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (resp_valid !== 1'b1 && k < 8);
    chk({7'h0, resp_valid}, 1, "answer");
    chk({7'h0, resp.hit}, h || pm, "hit");
    if (!h && !pm || op inside {0, 2, 3} || pm)
      chk(resp.data, dv, "data");
    if (h && op inside {3, 6, 7, 11} || pm)
      chk({7'h0, resp.skip}, sk, "skip");
    if (h && op inside {[8:10]})
      chk({7'h0, resp.carry}, c, "carry");
    chk(ipp, ptr, "pointer");
    chk(sp, 'h20 + sp5, "stack");
  endtask

  task automatic wrap_up();
    $display("Counts: %0d mismatches, %0d compares", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  initial
  begin
    for (int i = 0; i < 128; i++)
      m['hf80 + i] = (i ^ (i >> 4)) & 15;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(sp, 'h20, "stack reset");
    // Fill all RAM nibbles
    for (int i = 0; i < 64; i++)
      run(1, 1, i, 0, rnd(), 0);
    // Range edges for the direct modes
    for (int md = 0; md < 3; md++)
      foreach (bnd[i])
        run(md, md == 0 ? 6 : 0, bnd[i], 1, rnd(), 0);
    // Every bit and fixed-page operation
    for (int op = 4; op < 12; op++)
      run(0, op, 'hf0 + op, op & 3, 0, 1);
    for (int op = 4; op < 12; op++)
      run(4, op, op[0] ? 'hb0 + op : 'hf0 + op, op & 3, 0, op[1]);
    // Pointer wrap both ways
    run(6, 12, 0, 0, 'hff, 0);
    run(6, 13, 0, 0, 0, 0);
    run(6, 14, 0, 0, 0, 0);
    // Random mix, half the operands drawn from the RAM range
    repeat (1200)
    begin
      r = rnd();
      run(r % 7, r[7:4], r[31] ? r[15:8] : r[13:8], r[17:16], r[25:18],
          r[26]);
    end
    wrap_up();
  end
endmodule
